// ===== core/dsrf_top.sv
`timescale 1ns/10ps
// Purpose: scales, offsets, gains and clamps conversion samples into result registers
// Assumes: filter samples are synchronous to i_ref_clk, full scale 2^15
// Notes: converter clock is modelled as a tick from the divider on i_ref_clk
//
// How it works
// - results held as 16-bit two's complement
// - above +32767 store 7FFF
// - below -32768 store 8000
// - in-range negative stored as value plus 65536
// - in-range non-negative stored unchanged
// - gain one to eight from two bits
// - single-ended subtracts offset code over 1024
// - divider code picks third, quarter, fifth, sixth
module dsrf_top import dsrf_pkg::*; (
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic [7:0] i_addr,
  input wire logic [15:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic i_sample_valid,
  input wire logic [1:0] i_sample_chan,
  input wire logic i_sample_diff,
  input wire logic signed [19:0] i_sample_raw,
  output logic [15:0] o_rdata,
  output logic o_result_strobe,
  output logic [1:0] o_result_chan,
  output logic [15:0] o_result,
  output logic o_conv_tick,
  output logic [2:0] o_div_ratio
);
  typedef struct packed {
    logic [1:0] gain;
    logic [2:0] div_sel;
    logic [DSRF_CHANNELS-1:0][13:0] ofs;
    logic [DSRF_CHANNELS-1:0][15:0] res;
    logic signed [DSRF_PROD_W-1:0] prod;
    logic prod_v;
    logic [1:0] prod_ch;
    logic [15:0] rdata;
    logic strobe;
    logic [1:0] res_ch;
    logic [15:0] last;
    logic [2:0] div_cnt;
    logic [2:0] ratio;
    logic tick;
  } dsrf_state_t;

  dsrf_state_t st_reg;
  dsrf_state_t st_next;
  dsrf_sat_if sat_bus ();
  logic signed [DSRF_DIFF_W-1:0] diff_val;
  logic [3:0] gain_factor;
  logic [2:0] sel_ratio;

  dsrf_sat u_sat (
    .s(sat_bus.sat)
  );

  assign sat_bus.wide = st_reg.prod;

  always_comb begin
    unique case (st_reg.gain)
      2'h0: gain_factor = 4'h1;
      2'h1: gain_factor = 4'h2;
      2'h2: gain_factor = 4'h4;
      2'h3: gain_factor = 4'h8;
    endcase
    case (st_reg.div_sel)
      DSRF_DIV_THIRD: sel_ratio = DSRF_RATIO_3;
      DSRF_DIV_QUARTER: sel_ratio = DSRF_RATIO_4;
      DSRF_DIV_FIFTH: sel_ratio = DSRF_RATIO_5;
      default: sel_ratio = DSRF_RATIO_6;
    endcase
    if (i_sample_diff) begin
      diff_val = DSRF_DIFF_W'(i_sample_raw);
    end else begin
      // offset code / 1024 of full scale 2^15 is code * 32
      diff_val = DSRF_DIFF_W'(i_sample_raw) -
        $signed({2'h0, st_reg.ofs[i_sample_chan], 5'h00});
    end
  end

  always_comb begin
    st_next = st_reg;
    st_next.strobe = 1'b0;
    st_next.rdata = 16'h0000;
    st_next.prod_v = i_sample_valid;
    st_next.prod_ch = i_sample_chan;
    // widen both factors first so the product keeps every bit of a gain of eight
    st_next.prod = DSRF_PROD_W'(diff_val) *
      DSRF_PROD_W'($signed({1'b0, gain_factor}));
    if (st_reg.prod_v) begin
      st_next.res[st_reg.prod_ch] = sat_bus.code;
      st_next.last = sat_bus.code;
      st_next.res_ch = st_reg.prod_ch;
      st_next.strobe = 1'b1;
    end
    // divider restarts its count at each tick so a ratio change waits a period
    st_next.tick = 1'b0;
    if (st_reg.div_cnt >= st_reg.ratio - 3'h1) begin
      st_next.div_cnt = 3'h0;
      st_next.tick = 1'b1;
      st_next.ratio = sel_ratio;
    end else begin
      st_next.div_cnt = st_reg.div_cnt + 3'h1;
    end
    if (i_wr) begin
      if (i_addr == DSRF_CTRL_ADDR) begin
        st_next.gain = {i_wdata[DSRF_GAIN_HI_BIT], i_wdata[DSRF_GAIN_LO_BIT]};
        st_next.div_sel = i_wdata[DSRF_DIV_LSB +: 3];
      end
      for (int c = 0; c < DSRF_CHANNELS; c++) begin
        if (i_addr == DSRF_OFS_BASE + 8'(4 * c)) begin
          st_next.ofs[c] = i_wdata[13:0];
        end
      end
    end
    if (i_rd) begin
      if (i_addr == DSRF_CTRL_ADDR) begin
        st_next.rdata = {11'h000, st_reg.div_sel, st_reg.gain};
      end
      for (int c = 0; c < DSRF_CHANNELS; c++) begin
        if (i_addr == DSRF_OFS_BASE + 8'(4 * c)) begin
          st_next.rdata = {2'h0, st_reg.ofs[c]};
        end
        if (i_addr == DSRF_RES_BASE + 8'(4 * c)) begin
          st_next.rdata = st_reg.res[c];
        end
      end
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      st_reg <= '0;
      st_reg.gain <= DSRF_GAIN_RST;
      st_reg.div_sel <= DSRF_DIV_RST;
      st_reg.ratio <= DSRF_RATIO_6;
    end else begin
      st_reg <= st_next;
    end
  end

  assign o_rdata = st_reg.rdata;
  assign o_result_strobe = st_reg.strobe;
  assign o_result_chan = st_reg.res_ch;
  assign o_result = st_reg.last;
  assign o_conv_tick = st_reg.tick;
  assign o_div_ratio = st_reg.ratio;

  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);

  // formatting, clamp, gain, offset, latency, register read and third/sixth divider checks
  a_pos_clamp: assert property (st_reg.prod_v && st_reg.prod > DSRF_SAT_POS
    |=> o_result_strobe && o_result == 16'h7FFF) else $error("positive clamp missed");
  a_neg_clamp: assert property (st_reg.prod_v && st_reg.prod < DSRF_SAT_NEG
    |=> o_result == 16'h8000) else $error("negative clamp missed");
  a_neg_wrap_code: assert property (st_reg.prod_v && st_reg.prod < 0
    && st_reg.prod >= DSRF_SAT_NEG
    |=> o_result == 16'($past(st_reg.prod) + 26'sh0010000)) else $error("negative code wrong");
  a_pos_pass_code: assert property (st_reg.prod_v && st_reg.prod >= 0
    && st_reg.prod <= DSRF_SAT_POS
    |=> o_result == $past(st_reg.prod[15:0])) else $error("positive code altered");
  a_result_reg_read: assert property (o_result_strobe && i_rd && !st_reg.prod_v
    && i_addr == DSRF_RES_BASE + 8'(4 * o_result_chan)
    |=> o_rdata == $past(o_result)) else $error("result register mismatch");
  a_gain_eight_diff: assert property (i_sample_valid && i_sample_diff
    && st_reg.gain == 2'h3
    |=> st_reg.prod == 26'($past(i_sample_raw)) * 26'sh8) else $error("gain eight wrong");
  a_offset_subtract: assert property (i_sample_valid && !i_sample_diff
    && st_reg.gain == 2'h0
    |=> st_reg.prod == 26'($past(i_sample_raw)) -
      26'({$past(st_reg.ofs[i_sample_chan]), 5'h00})) else $error("offset not removed");
  a_div_third: assert property (o_conv_tick && o_div_ratio == DSRF_RATIO_3
    |=> !o_conv_tick [*2] ##1 o_conv_tick) else $error("third divider period wrong");
  a_div_sixth: assert property (o_conv_tick && o_div_ratio == DSRF_RATIO_6
    |=> !o_conv_tick [*5] ##1 o_conv_tick) else $error("sixth divider period wrong");
  a_no_wrap: assert property (o_result_strobe && $past(st_reg.prod) > 0
    |-> !o_result[15]) else $error("positive outcome wrapped");
  a_no_wrap_neg: assert property (o_result_strobe && $past(st_reg.prod) < 0
    |-> o_result[15]) else $error("negative outcome wrapped");
  a_result_latency: assert property (i_sample_valid
    |=> ##1 o_result_strobe && o_result_chan == $past(i_sample_chan, 2))
    else $error("result strobe late or on wrong channel");
  a_result_hold: assert property (!st_reg.prod_v
    |=> $stable(o_result)) else $error("result changed without a sample");

  // remaining gain, offset and control write checks
  a_gain_one_diff: assert property (i_sample_valid && i_sample_diff
    && st_reg.gain == 2'h0
    |=> st_reg.prod == 26'($past(i_sample_raw))) else $error("gain one wrong");
  a_gain_two_diff: assert property (i_sample_valid && i_sample_diff
    && st_reg.gain == 2'h1
    |=> st_reg.prod == 26'($past(i_sample_raw)) * 26'sh2) else $error("gain two wrong");
  a_gain_four_diff: assert property (i_sample_valid && i_sample_diff
    && st_reg.gain == 2'h2
    |=> st_reg.prod == 26'($past(i_sample_raw)) * 26'sh4) else $error("gain four wrong");
  a_ctrl_write: assert property (i_wr && i_addr == DSRF_CTRL_ADDR
    |=> st_reg.gain == $past({i_wdata[DSRF_GAIN_HI_BIT], i_wdata[DSRF_GAIN_LO_BIT]})
    && st_reg.div_sel == $past(i_wdata[DSRF_DIV_LSB +: 3])) else $error("control not stored");
  a_ofs_write: assert property (i_wr && i_addr == DSRF_OFS_BASE
    |=> st_reg.ofs[0] == $past(i_wdata[13:0])) else $error("offset code not stored");

  // divider checks
  a_div_quarter: assert property (o_conv_tick && o_div_ratio == DSRF_RATIO_4
    |=> !o_conv_tick [*3] ##1 o_conv_tick) else $error("quarter divider period wrong");
  a_div_fifth: assert property (o_conv_tick && o_div_ratio == DSRF_RATIO_5
    |=> !o_conv_tick [*4] ##1 o_conv_tick) else $error("fifth divider period wrong");
  a_ratio_hold: assert property (!o_conv_tick
    |-> $stable(o_div_ratio)) else $error("ratio changed between ticks");

  // main scenarios
  c_pos_sat: cover property (o_result_strobe && o_result == 16'h7FFF);
  c_neg_sat: cover property (o_result_strobe && o_result == 16'h8000);
  c_neg_in_range: cover property (o_result_strobe && o_result[15] && o_result != 16'h8000);
  c_quarter_tick: cover property (o_conv_tick && o_div_ratio == DSRF_RATIO_4);
  c_offset_zero: cover property (o_result_strobe && o_result == 16'h0000);
endmodule // dsrf_top

// ===== core/dsrf_pkg.sv
// Purpose: constants for the delta-sigma result formatter
// Assumes: registers sit on a plain strobe port with 8-bit byte addresses
// Notes: one aligned word per register, 16-bit data in the low bits
package dsrf_pkg;
  localparam int DSRF_CHANNELS = 4;
  localparam int DSRF_RAW_W = 20;
  localparam int DSRF_DIFF_W = 21;
  localparam int DSRF_PROD_W = 26;
  localparam logic [7:0] DSRF_CTRL_ADDR = 8'h00;
  localparam logic [7:0] DSRF_OFS_BASE = 8'h10;
  localparam logic [7:0] DSRF_RES_BASE = 8'h20;
  localparam int DSRF_GAIN_LO_BIT = 0;
  localparam int DSRF_GAIN_HI_BIT = 1;
  localparam int DSRF_DIV_LSB = 2;
  localparam logic [1:0] DSRF_GAIN_RST = 2'h0;
  localparam logic [2:0] DSRF_DIV_RST = 3'h0;
  localparam logic [2:0] DSRF_DIV_THIRD = 3'h3;
  localparam logic [2:0] DSRF_DIV_QUARTER = 3'h2;
  localparam logic [2:0] DSRF_DIV_FIFTH = 3'h1;
  localparam logic [2:0] DSRF_DIV_SIXTH = 3'h0;
  localparam logic [2:0] DSRF_RATIO_3 = 3'h3;
  localparam logic [2:0] DSRF_RATIO_4 = 3'h4;
  localparam logic [2:0] DSRF_RATIO_5 = 3'h5;
  localparam logic [2:0] DSRF_RATIO_6 = 3'h6;
  localparam logic signed [DSRF_PROD_W-1:0] DSRF_SAT_POS = 26'sh0007FFF;
  localparam logic signed [DSRF_PROD_W-1:0] DSRF_SAT_NEG = -26'sh0008000;
  localparam logic [15:0] DSRF_CODE_POS = 16'h7FFF;
  localparam logic [15:0] DSRF_CODE_NEG = 16'h8000;
  localparam int DSRF_OFS_SHIFT = 5;
endpackage

// ===== core/dsrf_sat_if.sv
`timescale 1ns/10ps
// Purpose: carries the full-precision outcome to the clamp and the code back
// Assumes: purely combinational exchange
// Notes: none
interface dsrf_sat_if;
  logic signed [25:0] wide;
  logic [15:0] code;
  modport fmt (output wide, input code);
  modport sat (input wide, output code);
endinterface

// ===== core/dsrf_sat.sv
`timescale 1ns/10ps
// Purpose: clamps a full-precision outcome into a 16-bit two's-complement code
// Assumes: input is signed and wider than 16 bits
// Notes: combinational
module dsrf_sat import dsrf_pkg::*; (
  dsrf_sat_if.sat s
);
  always_comb begin
    if (s.wide > DSRF_SAT_POS) begin
      s.code = DSRF_CODE_POS;
    end else if (s.wide < DSRF_SAT_NEG) begin
      s.code = DSRF_CODE_NEG;
    end else begin
      // low bits equal the outcome, or outcome plus 65536 when negative
      s.code = s.wide[15:0];
    end
  end
endmodule // dsrf_sat

// ===== testbench/test_delta_sigma_result_format.sv
`timescale 1ns/10ps
// Purpose: random and corner checks of result formatting, register port and divider
// Assumes: result strobe one cycle after the take edge, read data one cycle after the read
// Notes: seed fixed, so every run repeats
module test_delta_sigma_result_format;
  import dsrf_pkg::*;
  logic i_ref_clk = 0, i_rst = 1, i_wr = 0, i_rd = 0, i_sample_valid = 0, i_sample_diff = 0;
  logic [7:0] i_addr = 0;
  logic [15:0] i_wdata = 0, o_rdata, o_result;
  logic [1:0] i_sample_chan = 0, o_result_chan;
  logic signed [19:0] i_sample_raw = 0;
  logic o_result_strobe, o_conv_tick;
  logic [2:0] o_div_ratio;
  logic [13:0] ofs [4];
  logic [15:0] last [4];
  bit [31:0] seed = 90130;
  int n_mismatch = 0, check_count = 0, g, k, n;
  dsrf_top i_dut (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .i_sample_valid(i_sample_valid), .i_sample_chan(i_sample_chan),
    .i_sample_diff(i_sample_diff), .i_sample_raw(i_sample_raw), .o_rdata(o_rdata),
    .o_result_strobe(o_result_strobe), .o_result_chan(o_result_chan), .o_result(o_result),
    .o_conv_tick(o_conv_tick), .o_div_ratio(o_div_ratio));
  initial begin
    forever #10 i_ref_clk = ~i_ref_clk;
  end
  function automatic bit [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [15:0] fmt(logic signed [19:0] raw, logic [13:0] o, int gc, logic d);
    longint w;
    w = raw;
    if (!d) w -= 32 * longint'(o);
    w = w * (1 << gc);
    if (w > 32767) return 16'h7FFF;
    if (w < -32768) return 16'h8000;
    return w[15:0];
  endfunction
  function automatic logic [2:0] ratio(int c);
    return (c == 3) ? 3'h3 : (c == 2) ? 3'h4 : (c == 1) ? 3'h5 : 3'h6;
  endfunction
  task automatic chk(string nm, logic [15:0] exp, logic [15:0] got);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wr(logic [7:0] a, logic [15:0] d);
    @(posedge i_ref_clk);
    i_wr <= 1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_ref_clk);
    i_wr <= 0;
  endtask
  task automatic rd(logic [7:0] a, logic [15:0] exp, string nm);
    @(posedge i_ref_clk);
    i_rd <= 1;
    i_addr <= a;
    @(posedge i_ref_clk);
    i_rd <= 0;
    #1 chk(nm, exp, o_rdata);
  endtask
  task automatic send(logic [1:0] c, logic d, logic signed [19:0] raw, int gc);
    logic [15:0] e;
    e = fmt(raw, ofs[c], gc, d);
    @(posedge i_ref_clk);
    i_sample_valid <= 1;
    i_sample_chan <= c;
    i_sample_diff <= d;
    i_sample_raw <= raw;
    @(posedge i_ref_clk);
    i_sample_valid <= 0;
    // read the result register while the strobe still stands
    @(posedge i_ref_clk);
    i_rd <= 1;
    i_addr <= DSRF_RES_BASE + 8'(4 * c);
    #1 chk("strobe", 16'h0001, {15'h0, o_result_strobe});
    chk("result", e, o_result);
    chk("chan", {14'h0, c}, {14'h0, o_result_chan});
    last[c] = e;
    @(posedge i_ref_clk);
    i_rd <= 0;
    #1 chk("result_reg", e, o_rdata);
  endtask
  task automatic tick_gap(output int gap);
    int i;
    // look after the edge so a tick launched by it is seen
    #1;
    for (i = 0; i < 20 && o_conv_tick !== 1'b1; i++) @(posedge i_ref_clk) #1;
    gap = 0;
    do begin
      @(posedge i_ref_clk) #1;
      gap++;
    end while (o_conv_tick !== 1'b1 && gap < 20);
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    #400000 n_mismatch++;
    wrap_up();
  end
  initial begin
    repeat (10) @(posedge i_ref_clk);
    i_rst <= 0;
    @(posedge i_ref_clk) #1;
    chk("ratio_rst", 16'h0006, {13'h0, o_div_ratio});
    rd(DSRF_CTRL_ADDR, 16'h0000, "ctrl_rst");
    $display("test reset done");
    for (k = 0; k < 4; k++) begin
      ofs[k] = (k == 3) ? 14'h3FFF : 14'(rnd());
      wr(DSRF_OFS_BASE + 8'(4 * k), {2'h0, ofs[k]});
    end
    $display("test offsets done");
    for (g = 0; g < 4; g++) begin
      wr(DSRF_CTRL_ADDR, 16'(g));
      for (k = 0; k < 16; k++) begin
        case (k)
          0: send(2'd0, 1'b1, 20'sh7FFFF, g);
          1: send(2'd1, 1'b1, 20'sh80000, g);
          2: send(2'd2, 1'b1, 20'sh07FFF >>> g, g);
          3: send(2'd3, 1'b1, -20'sh08000 >>> g, g);
          4: send(2'd3, 1'b0, 20'sh00000, g);
          5: send(2'd1, 1'b1, 20'sh08000, g);
          6: send(2'd3, 1'b0, 20'sh7FFE0, g);
          7: send(2'd2, 1'b1, -20'sh08001, g);
          default: send(2'(rnd()), 1'(rnd()), 20'(rnd()) >>> (rnd() % 8), g);
        endcase
      end
      $display("test gain %0d done", g);
    end
    wr(DSRF_RES_BASE, 16'h1234);
    rd(DSRF_RES_BASE, last[0], "ro_result");
    rd(8'h30, 16'h0000, "unmapped");
    wr(DSRF_CTRL_ADDR, 16'hFFFF);
    rd(DSRF_CTRL_ADDR, 16'h001F, "ctrl_bits");
    $display("test register port done");
    for (k = 0; k < 8; k++) begin
      wr(DSRF_CTRL_ADDR, 16'(k << DSRF_DIV_LSB));
      tick_gap(n);
      tick_gap(n);
      chk("tick_gap", {13'h0, ratio(k)}, 16'(n));
      chk("ratio", {13'h0, ratio(k)}, {13'h0, o_div_ratio});
    end
    $display("test divider done");
    wrap_up();
  end
endmodule // test_delta_sigma_result_format
